// file: inc/dds_regs_defs.svh
/*
  Offsets, field positions, reset values and widths of the tuning, phase and
  output routing registers. Assumes a 13-bit register address from the
  serial control port decoder.
*/
`ifndef DDS_REGS_DEFS_SVH
`define DDS_REGS_DEFS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define REG_ADDR_W        13
`define REG_DATA_W        8
`define ACC_W             48
`define PHASE_W           14
`define FTW_BYTES         6
`define POW_HIGH_W        6
`define STARTUP_W         4
`define OCTANT_W          3

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_FTW_BYTE0    13'h01a6
`define ADDR_FTW_BYTE4    13'h01aa
`define ADDR_FTW_BYTE5    13'h01ab
`define ADDR_POW_LOW      13'h01ac
`define ADDR_POW_HIGH     13'h01ad
`define ADDR_DIFF_CTRL    13'h0200
`define ADDR_SE_CTRL      13'h0201

// ----------------------------------------------------------------------
// Field positions and encodings
// ----------------------------------------------------------------------
`define DIFF_INVERT_BIT   4
`define DOUBLER_LSB       0
`define DOUBLER_W         2
`define DOUBLER_BYPASS    2'h1
`define DOUBLER_ENGAGED   2'h2
`define SE_MUX_BIT        0
`define STARTUP_FTW_SHIFT 40

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_BYTE          8'h00
`define RST_FTW           48'h0000_0000_0000
`define RST_POW           14'h0000
`define RST_INVERT        1'b0
`define RST_SE_MUX        1'b0

`endif

// file: inc/dds_regs_pkg.sv
/*
  Types shared by the tuning, phase and output routing logic.
  Assumes dds_regs_defs.svh is on the include path.
*/
`include "dds_regs_defs.svh"

package dds_regs_pkg;

  typedef logic [`ACC_W-1:0]      tuning_word_t;
  typedef logic [`PHASE_W-1:0]    phase_word_t;
  typedef logic [`REG_ADDR_W-1:0] reg_addr_t;
  typedef logic [`REG_DATA_W-1:0] reg_byte_t;

  typedef enum logic [`DOUBLER_W-1:0] {
    DOUBLER_OFF = `DOUBLER_BYPASS,
    DOUBLER_ON  = `DOUBLER_ENGAGED
  } doubler_t;

endpackage

// file: design/phase_accum.sv
/*
  Phase accumulator of the synthesizer with phase offset adder.
  Assumes the tuning and phase words it receives are already coherent.
*/
`timescale 1ns/1ps
`include "dds_regs_defs.svh"

module phase_accum (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  dds_regs_pkg::tuning_word_t tuning_word,
  input  dds_regs_pkg::phase_word_t  phase_offset_word,
  output dds_regs_pkg::phase_word_t  dds_phase,
  output logic [`OCTANT_W-1:0]      phase_octant
);
  import dds_regs_pkg::*;

  tuning_word_t acc;
  phase_word_t  next_phase;

  // ----------------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------------
  // Never cleared on a tuning change, so the phase stays continuous
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc <= `RST_FTW;
    end else begin
      acc <= acc + tuning_word;
    end
  end

  assign next_phase = phase_word_t'(acc[`ACC_W-1 -: `PHASE_W] + phase_offset_word);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dds_phase <= `RST_POW;
    end else begin
      dds_phase <= next_phase;
    end
  end

  // Offset steps show as octant jumps of the applied phase
  assign phase_octant = dds_phase[`PHASE_W-1 -: `OCTANT_W];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_phase_continuous: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst) |-> acc == tuning_word_t'($past(acc) + $past(tuning_word)))
    else $error("accumulator lost phase continuity");

  a_phase_offset_sum: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst) |-> dds_phase == phase_word_t'($past(acc[`ACC_W-1 -: `PHASE_W])
                                 + $past(phase_offset_word)))
    else $error("output phase is not accumulator plus offset");

endmodule

// file: design/output_router.sv
/*
  Output routing: differential driver polarity and doubler choice, and the
  single-ended driver source around the output divider.
  Assumes the three input levels are synchronous to core_clk.
*/
`timescale 1ns/1ps
`include "dds_regs_defs.svh"

module output_router (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             diff_out_invert,
  input  dds_regs_pkg::doubler_t diff_out_freq_doubler,
  input  wire logic             se_out_from_divider,
  input  wire logic             level_undivided,
  input  wire logic             level_doubled,
  input  wire logic             level_divided,
  output logic                  diff_out_p,
  output logic                  diff_out_n,
  output logic                  se_out
);
  import dds_regs_pkg::*;

  logic diff_source;
  logic next_diff;
  logic next_se;

  // ----------------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------------
  // Codes other than engaged fall back to the bypass path
  assign diff_source = (diff_out_freq_doubler == DOUBLER_ON) ? level_doubled
                                                             : level_undivided;
  assign next_diff   = diff_source ^ diff_out_invert;
  assign next_se     = se_out_from_divider ? level_divided : level_undivided;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      diff_out_p <= 1'b0;
      diff_out_n <= 1'b1;
      se_out     <= 1'b0;
    end else begin
      diff_out_p <= next_diff;
      diff_out_n <= ~next_diff;
      se_out     <= next_se;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_diff_polarity: assert property (@(posedge core_clk) disable iff (rst)
    diff_out_invert && diff_out_freq_doubler != DOUBLER_ON
    |=> diff_out_p == !$past(level_undivided) && diff_out_n == $past(level_undivided))
    else $error("inverted polarity not applied");

  a_doubler_path: assert property (@(posedge core_clk) disable iff (rst)
    diff_out_freq_doubler == DOUBLER_ON && !diff_out_invert
    |=> diff_out_p == $past(level_doubled))
    else $error("doubler path not selected");

  a_se_mux: assert property (@(posedge core_clk) disable iff (rst)
    !se_out_from_divider |=> se_out == $past(level_undivided))
    else $error("single-ended output not fed from divider input");

endmodule

// file: design/dds_tuning_phase_output_regs.sv
/*
  Tuning, phase offset and output routing registers of the synthesizer,
  with the accumulator and output routing behind them.
  Assumes the serial control port has decoded each transfer into one byte
  access on reg_addr with a one-cycle reg_wr or reg_rd strobe, and that
  update_strobe is a one-cycle pulse from the same port.
*/
`timescale 1ns/1ps
`include "dds_regs_defs.svh"

module dds_tuning_phase_output_regs (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  dds_regs_pkg::reg_addr_t   reg_addr,
  input  wire logic                 reg_wr,
  input  dds_regs_pkg::reg_byte_t   reg_wdata,
  input  wire logic                 reg_rd,
  output dds_regs_pkg::reg_byte_t   reg_rdata,
  input  wire logic                 update_strobe,
  input  wire logic                 startup_select_first,
  input  wire logic                 startup_select_second,
  input  wire logic                 startup_select_third,
  input  wire logic                 startup_select_last,
  input  wire logic                 level_undivided,
  input  wire logic                 level_doubled,
  input  wire logic                 level_divided,
  output dds_regs_pkg::tuning_word_t tuning_word,
  output dds_regs_pkg::phase_word_t  phase_offset_word,
  output dds_regs_pkg::phase_word_t  dds_phase,
  output logic [`OCTANT_W-1:0]      phase_octant,
  output logic                      diff_out_p,
  output logic                      diff_out_n,
  output logic                      se_out
);
  import dds_regs_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg_byte_t              ftw_byte [`FTW_BYTES];
  logic [`FTW_BYTES-1:0]  ftw_hit;
  tuning_word_t           shadow_ftw;
  phase_word_t            shadow_pow;
  logic                   diff_out_invert;
  doubler_t               diff_out_freq_doubler;
  logic                   se_out_from_divider;
  logic                   boot_done;
  logic                   boot_load;
  logic                   apply;
  logic [`STARTUP_W-1:0]  startup_code;
  tuning_word_t           startup_ftw;
  reg_addr_t              ftw_offset;
  logic                   ftw_range;
  logic                   wr_pow_low;
  logic                   wr_pow_high;
  logic                   wr_diff;
  logic                   wr_se;
  reg_byte_t              rd_ftw;
  reg_byte_t              rd_pow_low;
  reg_byte_t              rd_pow_high;
  reg_byte_t              rd_diff;
  reg_byte_t              rd_se;
  reg_byte_t              next_rdata;

  // ----------------------------------------------------------------------
  // Startup default
  // ----------------------------------------------------------------------
  // Pins are caught in the first cycle after reset release, not under reset
  assign startup_code = {startup_select_last, startup_select_third,
                         startup_select_second, startup_select_first};
  assign startup_ftw  = tuning_word_t'(startup_code) << `STARTUP_FTW_SHIFT;
  assign boot_load    = !boot_done;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      boot_done <= 1'b0;
    end else begin
      boot_done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  assign ftw_offset  = reg_addr - `ADDR_FTW_BYTE0;
  assign ftw_range   = (reg_addr >= `ADDR_FTW_BYTE0) && (reg_addr <= `ADDR_FTW_BYTE5);
  assign wr_pow_low  = reg_wr && (reg_addr == `ADDR_POW_LOW);
  assign wr_pow_high = reg_wr && (reg_addr == `ADDR_POW_HIGH);
  assign wr_diff     = reg_wr && (reg_addr == `ADDR_DIFF_CTRL);
  assign wr_se       = reg_wr && (reg_addr == `ADDR_SE_CTRL);

  // ----------------------------------------------------------------------
  // Tuning word bytes
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < `FTW_BYTES; i++) begin : g_ftw
    assign ftw_hit[i] = reg_wr && (reg_addr == `ADDR_FTW_BYTE0 + reg_addr_t'(i));
    assign shadow_ftw[8*i +: 8] = ftw_byte[i];

    always_ff @(posedge core_clk) begin
      if (rst) begin
        ftw_byte[i] <= `RST_BYTE;
      end else if (boot_load) begin
        ftw_byte[i] <= startup_ftw[8*i +: 8];
      end else if (ftw_hit[i]) begin
        ftw_byte[i] <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Phase offset and driver controls
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shadow_pow <= `RST_POW;
    end else if (wr_pow_low) begin
      shadow_pow[7:0] <= reg_wdata;
    end else if (wr_pow_high) begin
      shadow_pow[`PHASE_W-1:8] <= reg_wdata[`POW_HIGH_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      diff_out_invert       <= `RST_INVERT;
      diff_out_freq_doubler <= DOUBLER_OFF;
    end else if (wr_diff) begin
      diff_out_invert       <= reg_wdata[`DIFF_INVERT_BIT];
      diff_out_freq_doubler <= doubler_t'(reg_wdata[`DOUBLER_LSB +: `DOUBLER_W]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      se_out_from_divider <= `RST_SE_MUX;
    end else if (wr_se) begin
      se_out_from_divider <= reg_wdata[`SE_MUX_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Coherent transfer to the core
  // ----------------------------------------------------------------------
  // Bytes collect in the shadows; the core only sees whole words
  assign apply = update_strobe && boot_done;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tuning_word       <= `RST_FTW;
      phase_offset_word <= `RST_POW;
    end else if (boot_load) begin
      tuning_word       <= startup_ftw;
    end else if (apply) begin
      tuning_word       <= shadow_ftw;
      phase_offset_word <= shadow_pow;
    end
  end

  // ----------------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------------
  // Reserved bits and unmapped addresses read as zero
  assign rd_ftw      = ftw_range ? ftw_byte[ftw_offset[2:0]] : `RST_BYTE;
  assign rd_pow_low  = shadow_pow[7:0];
  assign rd_pow_high = reg_byte_t'(shadow_pow[`PHASE_W-1:8]);
  assign rd_diff     = reg_byte_t'({diff_out_invert, 2'h0, diff_out_freq_doubler});
  assign rd_se       = reg_byte_t'(se_out_from_divider);
  assign next_rdata  = ftw_range                      ? rd_ftw      :
                       (reg_addr == `ADDR_POW_LOW)    ? rd_pow_low  :
                       (reg_addr == `ADDR_POW_HIGH)   ? rd_pow_high :
                       (reg_addr == `ADDR_DIFF_CTRL)  ? rd_diff     :
                       (reg_addr == `ADDR_SE_CTRL)    ? rd_se       : `RST_BYTE;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= `RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Core and outputs
  // ----------------------------------------------------------------------
  phase_accum u_accum (
    .core_clk          (core_clk),
    .rst               (rst),
    .tuning_word       (tuning_word),
    .phase_offset_word (phase_offset_word),
    .dds_phase         (dds_phase),
    .phase_octant      (phase_octant)
  );

  // Doubler engaged also needs a host setting outside this block
  output_router u_router (
    .core_clk              (core_clk),
    .rst                   (rst),
    .diff_out_invert       (diff_out_invert),
    .diff_out_freq_doubler (diff_out_freq_doubler),
    .se_out_from_divider   (se_out_from_divider),
    .level_undivided       (level_undivided),
    .level_doubled         (level_doubled),
    .level_divided         (level_divided),
    .diff_out_p            (diff_out_p),
    .diff_out_n            (diff_out_n),
    .se_out                (se_out)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_startup_load: assert property (
    boot_load |=> tuning_word == $past(startup_ftw)
                                  && shadow_ftw == $past(startup_ftw))
    else $error("startup tuning word not loaded");

  a_ftw_top_byte: assert property (
    boot_done && reg_wr && reg_addr == `ADDR_FTW_BYTE5
    |=> shadow_ftw[`ACC_W-1 -: 8] == $past(reg_wdata))
    else $error("top tuning byte not stored in bits 47:40");

  a_ftw_low_byte: assert property (
    boot_done && reg_wr && reg_addr == `ADDR_FTW_BYTE0
    |=> shadow_ftw[7:0] == $past(reg_wdata))
    else $error("low tuning byte not stored in bits 7:0");

  a_ftw_coherent: assert property (
    boot_done && !update_strobe |=> $stable(tuning_word) && $stable(phase_offset_word))
    else $error("core word changed without update");

  a_ftw_apply: assert property (
    apply |=> tuning_word == $past(shadow_ftw) && phase_offset_word == $past(shadow_pow))
    else $error("update did not transfer shadow words");

  a_pow_high_byte: assert property (
    reg_wr && reg_addr == `ADDR_POW_HIGH
    |=> shadow_pow[`PHASE_W-1:8] == $past(reg_wdata[`POW_HIGH_W-1:0]))
    else $error("phase high byte not stored in bits 13:8");

  a_pow_reserved: assert property (
    reg_rd && reg_addr == `ADDR_POW_HIGH |=> reg_rdata[7:`POW_HIGH_W] == 2'h0)
    else $error("phase high byte reserved bits not zero");

  a_invert_reach: assert property (
    wr_diff && reg_wdata[`DIFF_INVERT_BIT] && reg_wdata[1:0] == `DOUBLER_BYPASS
    |=> ##1 diff_out_p == !$past(level_undivided))
    else $error("written invert bit did not reach driver");

  a_se_divided: assert property (
    wr_se && reg_wdata[`SE_MUX_BIT] |=> ##1 se_out == $past(level_divided))
    else $error("divider output not routed to single-ended driver");

  c_startup: cover property (boot_load ##1 boot_done);
  c_update: cover property (ftw_hit[`FTW_BYTES-1] ##[1:8] apply);
  c_doubler: cover property (wr_diff && reg_wdata[1:0] == `DOUBLER_ENGAGED);
  c_read_ftw: cover property (reg_rd && ftw_range);

endmodule

// file: tb/dds_host_model.sv
/*
  Host model of the serial control port side: byte writes, byte reads and update pulses.
  Assumes each task is entered from the bench process on any time step.
*/
`timescale 1ns/1ps
`include "dds_regs_defs.svh"

module dds_host_model (
  input  wire logic               core_clk,
  input  dds_regs_pkg::reg_byte_t reg_rdata,
  output dds_regs_pkg::reg_addr_t reg_addr,
  output logic                    reg_wr,
  output dds_regs_pkg::reg_byte_t reg_wdata,
  output logic                    reg_rd,
  output logic                    update_strobe
);
  import dds_regs_pkg::*;

  initial begin
    reg_addr = 13'h1fff;
    reg_wr = 1'b0;
    reg_wdata = 8'ha5;
    reg_rd = 1'b0;
    update_strobe = 1'b0;
  end

  // Released address and data lines show the inverse of the last value
  task automatic cyc(input reg_addr_t a, input reg_byte_t d, input logic w);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = ~w;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    cyc(a, d, 1'b1);
    if (a == `ADDR_DIFF_CTRL && d[1:0] == `DOUBLER_ENGAGED) begin
      cyc(13'h0010, 8'h20, 1'b1);
    end
  endtask

  task automatic rd(input reg_addr_t a, output reg_byte_t d);
    cyc(a, ~reg_wdata, 1'b0);
    d = reg_rdata;
  endtask

  task automatic upd();
    @(posedge core_clk);
    #1;
    update_strobe = 1'b1;
    @(posedge core_clk);
    #1;
    update_strobe = 1'b0;
  endtask
endmodule

// file: tb/dds_tuning_phase_output_regs_tb_top.sv
/*
  Self-checking bench of the tuning, phase and output routing registers.
  Assumes dds_host_model drives the register port and the bench drives the rest.
*/
`timescale 1ns/1ps
`include "dds_regs_defs.svh"
`define CMP(g, e) chk(64'(g), 64'(e))

module dds_tuning_phase_output_regs_tb_top;
  import dds_regs_pkg::*;

  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  reg_addr_t    reg_addr;
  logic         reg_wr;
  reg_byte_t    reg_wdata;
  logic         reg_rd;
  reg_byte_t    reg_rdata;
  logic         update_strobe;
  logic [3:0]   code;
  logic         lu = 1'b0;
  logic         ld = 1'b0;
  logic         lv = 1'b0;
  tuning_word_t tuning_word;
  phase_word_t  phase_offset_word;
  phase_word_t  dds_phase;
  logic [2:0]   phase_octant;
  logic         diff_out_p;
  logic         diff_out_n;
  logic         se_out;
  int           n_mismatch = 0;
  int           n_compared = 0;

  always #2.5 core_clk = ~core_clk;

  dds_host_model u_dds_host_model (
    .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .update_strobe(update_strobe));

  dds_tuning_phase_output_regs u_dds_tuning_phase_output_regs (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .update_strobe(update_strobe), .startup_select_first(code[0]),
    .startup_select_second(code[1]), .startup_select_third(code[2]),
    .startup_select_last(code[3]), .level_undivided(lu), .level_doubled(ld),
    .level_divided(lv), .tuning_word(tuning_word), .phase_offset_word(phase_offset_word),
    .dds_phase(dds_phase), .phase_octant(phase_octant), .diff_out_p(diff_out_p),
    .diff_out_n(diff_out_n), .se_out(se_out));

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic exp_p(logic [1:0] dbl, logic inv, logic u, logic d);
    return ((dbl == `DOUBLER_ENGAGED) ? d : u) ^ inv;
  endfunction

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  task automatic set_top(input logic [13:0] w);
    u_dds_host_model.wr(`ADDR_FTW_BYTE5, w[13:6]);
    u_dds_host_model.wr(`ADDR_FTW_BYTE4, {w[5:0], 2'b00});
  endtask

  task automatic phase_test();
    logic [13:0] w1, w2, dl;
    phase_word_t pv;
    w1 = 14'($urandom);
    w2 = 14'($urandom);
    set_top(w1);
    u_dds_host_model.upd();
    repeat (4) @(posedge core_clk);
    #1;
    pv = dds_phase;
    repeat (4) begin
      @(posedge core_clk);
      #1;
      `CMP(14'(dds_phase - pv), w1);
      pv = dds_phase;
    end
    set_top(w2);
    pv = dds_phase;
    fork
      u_dds_host_model.upd();
      repeat (8) begin
        @(posedge core_clk);
        #1;
        dl = 14'(dds_phase - pv);
        `CMP(dl === w1 || dl === w2, 1'b1);
        `CMP(phase_octant, dds_phase[13:11]);
        pv = dds_phase;
      end
    join
    `CMP(dl, w2);
    $display("test phase_continuity done");
  endtask

  task automatic word_test();
    reg_byte_t    b [8];
    reg_byte_t    d;
    tuning_word_t old;
    for (int t = 0; t < 4; t++) begin
      old = tuning_word;
      for (int k = 0; k < 8; k++) b[k] = 8'($urandom);
      if (t == 0) b[7] = 8'hff;
      for (int k = 0; k < 6; k++) u_dds_host_model.wr(`ADDR_FTW_BYTE0 + 13'(k), b[k]);
      u_dds_host_model.wr(`ADDR_POW_LOW, b[6]);
      u_dds_host_model.wr(`ADDR_POW_HIGH, b[7]);
      for (int k = 0; k < 6; k++) begin
        u_dds_host_model.rd(`ADDR_FTW_BYTE0 + 13'(k), d);
        `CMP(d, b[k]);
      end
      u_dds_host_model.rd(`ADDR_POW_HIGH, d);
      `CMP(d, {2'b00, b[7][5:0]});
      `CMP(tuning_word, old);
      u_dds_host_model.upd();
      `CMP(tuning_word, {b[5], b[4], b[3], b[2], b[1], b[0]});
      `CMP(phase_offset_word, {b[7][5:0], b[6]});
    end
    $display("test tuning_phase_words done");
  endtask

  task automatic route_test();
    reg_byte_t d;
    logic [1:0] dbl;
    logic inv, mux;
    for (int c = 0; c < 16; c++) begin
      {mux, inv, dbl} = 4'(c);
      u_dds_host_model.wr(`ADDR_DIFF_CTRL, {3'($urandom), inv, 2'($urandom), dbl});
      u_dds_host_model.wr(`ADDR_SE_CTRL, {7'($urandom), mux});
      u_dds_host_model.rd(`ADDR_DIFF_CTRL, d);
      `CMP(d, {3'b000, inv, 2'b00, dbl});
      u_dds_host_model.rd(`ADDR_SE_CTRL, d);
      `CMP(d, {7'h00, mux});
      u_dds_host_model.rd(13'h0010, d);
      `CMP(d, 8'h00);
      repeat (6) begin
        @(posedge core_clk);
        #1;
        {lu, ld, lv} = 3'($urandom);
        @(posedge core_clk);
        #1;
        `CMP(diff_out_p, exp_p(dbl, inv, lu, ld));
        `CMP(diff_out_n, !exp_p(dbl, inv, lu, ld));
        `CMP(se_out, mux ? lv : lu);
      end
    end
    $display("test output_routing done");
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    reg_byte_t d;
    void'($urandom(56502));
    code = 4'($urandom);
    repeat (12) @(posedge core_clk);
    #1;
    rst = 1'b0;
    @(posedge core_clk);
    #1;
    `CMP(tuning_word, {4'h0, code, 40'h0});
    u_dds_host_model.rd(`ADDR_FTW_BYTE5, d);
    `CMP(d, {4'h0, code});
    u_dds_host_model.rd(`ADDR_DIFF_CTRL, d);
    `CMP(d, 8'h01);
    u_dds_host_model.rd(`ADDR_SE_CTRL, d);
    `CMP(d, 8'h00);
    u_dds_host_model.rd(`ADDR_POW_LOW, d);
    `CMP(d, 8'h00);
    $display("test reset_values done");
    phase_test();
    word_test();
    route_test();
    summarize();
  end
endmodule
